// *** hdl/psc_pkg.sv ***
// Package of constants and types for the power-on strap capture block
package psc_pkg;
    // ****************************************
    // Port addresses and register offsets
    // ****************************************
    localparam logic [15:0] IDX_PORT = 16'h0022;
    localparam logic [15:0] DATA_PORT = 16'h0023;
    localparam logic [7:0] OFS_CAPTURE0 = 8'h4A;
    localparam logic [7:0] OFS_CAPTURE1 = 8'h4B;
    localparam logic [7:0] OFS_CAPTURE2 = 8'h4C;
    localparam logic [7:0] OFS_HOST_CLK = 8'h5F;
    localparam logic [7:0] UNMAPPED_VAL = 8'hFF;
    localparam logic [7:0] IDX_RESET = 8'h00;
    // ****************************************
    // Strap pin positions on the memory data bus, bus width and synchroniser depth
    // ****************************************
    localparam int PIN_W = 64;
    localparam int SYNC_DEPTH = 3;
    localparam int PIN_DIV = 4;
    localparam int PIN_DIV_FAST = 17;
    localparam int PIN_RSV_HI = 23;
    localparam int PIN_CPU_X2 = 40;
    localparam int PIN_BUS_SEL = 44;
    // ****************************************
    // Decoded settings
    // ****************************************
    typedef enum logic [1:0] {PSC_DIV4, PSC_DIV3, PSC_DIV2} psc_pcidiv_t;
    typedef enum logic [1:0] {PSC_PLL_16_32, PSC_PLL_32_64, PSC_PLL_RSV} psc_pllrange_t;
    typedef enum logic [3:0] {
        PSC_HF_25, PSC_HF_50, PSC_HF_60, PSC_HF_66, PSC_HF_75,
        PSC_HF_82P5, PSC_HF_90, PSC_HF_100, PSC_HF_RSV
    } psc_hfreq_t;
    localparam logic [4:0] HC_25 = 5'h00;
    localparam logic [4:0] HC_50 = 5'h01;
    localparam logic [4:0] HC_60 = 5'h02;
    localparam logic [4:0] HC_66 = 5'h03;
    localparam logic [4:0] HC_75 = 5'h09;
    localparam logic [4:0] HC_82P5 = 5'h0E;
    localparam logic [4:0] HC_90 = 5'h13;
    localparam logic [4:0] HC_100 = 5'h19;
endpackage : psc_pkg

// *** hdl/psc_strap_capture.sv ***
// Power-on strap capture: sampling, index/data register port and clock decode
// Functional notes
// (RULE1) Register 4Ah holds pins 7..2 in bits 7..2; bits 1..0 reserved zero.
// (RULE2) Bits 7..6 of 4Ah pick PCI PLL range 16-32, 32-64, or reserved.
// (RULE3) Pin 5 low asynchronous, high synchronous memory and host clocks.
// (RULE4) PCI divisor: pin4 low /4; pin4 high gives /3, or /2 when pin17 high.
// (RULE5) Register 4Bh holds pins 11 and 10 in bits 3 and 2.
// (RULE6) Register 4Ch holds pin 23 in bit 5, pins 19..16 in bits 3..0.
// (RULE7) Register 5Fh holds pins 3,2,26,25,24 in bits 7..3.
// (RULE8) Five host clock bits select synthesizer frequency from eight codes.
// (RULE9) Pin 40 low gives CPU clock times one, high times two.
// (RULE10) Pin 44 low selects ISA bus, high selects local bus.
// (RULE11) Index port 0022h selects register, data port 0023h reads it.
// (RULE12) Board fits prescribed pulls on reserved straps.
// (RULE13) Straps stay stable during reset input low until reset output rises.
// (RULE14) Captured values freeze when reset output deasserts, until next reset.
`timescale 1ns/10ps
module psc_strap_capture
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [psc_pkg::PIN_W-1:0] memory_data_pins,
    input wire logic system_reset_input_n,
    output logic system_reset_output_n,
    input wire logic ioWr,
    input wire logic ioRd,
    input wire logic [15:0] ioAddr,
    input wire logic [7:0] ioWdata,
    output logic [7:0] ioRdata,
    output logic ioRvalid,
    output psc_pkg::psc_pllrange_t pci_clock_pll,
    output psc_pkg::psc_pcidiv_t pci_clock_output,
    output logic memHostSync,
    output psc_pkg::psc_hfreq_t hostFreq,
    output logic cpuClockX2,
    output logic localBusSel
);
    psc_strap_if strapBus ();
    logic [psc_pkg::PIN_W-1:0] pinsSync;
    logic pinsStable;
    logic [2:0] rstSync;
    logic captureOpen;
    logic [7:0] indexReg;

    // ****************************************
    // Pin synchronisation
    // ****************************************
    psc_strap_sync uSync
    (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pinIn(memory_data_pins),
        .pinSync(pinsSync),
        .pinStable(pinsStable)
    );

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            rstSync <= '0;
        else
            rstSync <= {rstSync[1:0], system_reset_input_n};
    end

    // ****************************************
    // Capture window
    // ****************************************
    // Window stays open while reset input is low and for four clock edges after it rises,
    // so the final sample is taken from straps the board still holds steady.
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            captureOpen <= 1'b1;
            system_reset_output_n <= 1'b0;
        end
        else if (rstSync[2] == 1'b0 && rstSync[1] == 1'b0)
        begin
            captureOpen <= 1'b1;
            system_reset_output_n <= 1'b0;
        end
        else if (rstSync[2] == 1'b1 && rstSync[1] == 1'b1)
        begin
            captureOpen <= 1'b0; // RULE14
            system_reset_output_n <= ~captureOpen; // RULE13
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            strapBus.capture0 <= '0;
            strapBus.capture1 <= '0;
            strapBus.capture2 <= '0;
            strapBus.hostClockStrap <= '0;
            strapBus.cpuX2 <= 1'b0;
            strapBus.localBus <= 1'b0;
        end
        else if (captureOpen && pinsStable) // RULE14
        begin
            strapBus.capture0 <= {pinsSync[7:2], 2'b00}; // RULE1
            strapBus.capture1 <= {4'h0, pinsSync[11:10], 2'b00}; // RULE5
            strapBus.capture2 <= {2'b00, pinsSync[psc_pkg::PIN_RSV_HI], 1'b0,
                pinsSync[19:16]}; // RULE6
            strapBus.hostClockStrap <= {pinsSync[3:2], pinsSync[26:24], 3'b000}; // RULE7
            strapBus.cpuX2 <= pinsSync[psc_pkg::PIN_CPU_X2]; // RULE9
            strapBus.localBus <= pinsSync[psc_pkg::PIN_BUS_SEL]; // RULE10
        end
    end

    // ****************************************
    // Index/data register port
    // ****************************************
    function automatic logic [7:0] regSelect(input logic [7:0] idx, input logic [7:0] s0,
        input logic [7:0] s1, input logic [7:0] s2, input logic [7:0] hc);
        unique case (idx)
            psc_pkg::OFS_CAPTURE0: regSelect = s0;
            psc_pkg::OFS_CAPTURE1: regSelect = s1;
            psc_pkg::OFS_CAPTURE2: regSelect = s2;
            psc_pkg::OFS_HOST_CLK: regSelect = hc;
            default: regSelect = psc_pkg::UNMAPPED_VAL;
        endcase
    endfunction : regSelect

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            indexReg <= psc_pkg::IDX_RESET;
        else if (ioWr && ioAddr == psc_pkg::IDX_PORT)
            indexReg <= ioWdata; // RULE11
    end

    // Data port writes are ignored: every strap register is read-only
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ioRdata <= '0;
            ioRvalid <= 1'b0;
        end
        else
        begin
            ioRvalid <= ioRd && (ioAddr == psc_pkg::IDX_PORT || ioAddr == psc_pkg::DATA_PORT);
            if (ioRd && ioAddr == psc_pkg::DATA_PORT)
                ioRdata <= regSelect(indexReg, strapBus.capture0, strapBus.capture1,
                    strapBus.capture2, strapBus.hostClockStrap); // RULE11
            else if (ioRd && ioAddr == psc_pkg::IDX_PORT)
                ioRdata <= indexReg;
            else
                ioRdata <= '0;
        end
    end

    // ****************************************
    // Clock setting decode
    // ****************************************
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pci_clock_pll <= psc_pkg::PSC_PLL_16_32;
            pci_clock_output <= psc_pkg::PSC_DIV4;
            memHostSync <= 1'b0;
            cpuClockX2 <= 1'b0;
            localBusSel <= 1'b0;
        end
        else
        begin
            if (strapBus.capture0[7])
                pci_clock_pll <= psc_pkg::PSC_PLL_RSV; // RULE2
            else if (strapBus.capture0[6])
                pci_clock_pll <= psc_pkg::PSC_PLL_32_64;
            else
                pci_clock_pll <= psc_pkg::PSC_PLL_16_32;
            if (!strapBus.capture0[psc_pkg::PIN_DIV])
                pci_clock_output <= psc_pkg::PSC_DIV4; // RULE4
            else if (strapBus.capture2[1])
                pci_clock_output <= psc_pkg::PSC_DIV2;
            else
                pci_clock_output <= psc_pkg::PSC_DIV3;
            memHostSync <= strapBus.capture0[5]; // RULE3
            cpuClockX2 <= strapBus.cpuX2; // RULE9
            localBusSel <= strapBus.localBus; // RULE10
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            hostFreq <= psc_pkg::PSC_HF_25;
        else
        begin
            unique case (strapBus.hostClockStrap[7:3]) // RULE8
                psc_pkg::HC_25: hostFreq <= psc_pkg::PSC_HF_25;
                psc_pkg::HC_50: hostFreq <= psc_pkg::PSC_HF_50;
                psc_pkg::HC_60: hostFreq <= psc_pkg::PSC_HF_60;
                psc_pkg::HC_66: hostFreq <= psc_pkg::PSC_HF_66;
                psc_pkg::HC_75: hostFreq <= psc_pkg::PSC_HF_75;
                psc_pkg::HC_82P5: hostFreq <= psc_pkg::PSC_HF_82P5;
                psc_pkg::HC_90: hostFreq <= psc_pkg::PSC_HF_90;
                psc_pkg::HC_100: hostFreq <= psc_pkg::PSC_HF_100;
                default: hostFreq <= psc_pkg::PSC_HF_RSV;
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    chk_frozen_after_release: assert property (@(posedge mclk) disable iff (sys_rst)
        (system_reset_output_n && $past(system_reset_output_n)) |-> $stable(strapBus.capture0)
        && $stable(strapBus.hostClockStrap)) else $error("strap changed after release"); // RULE14
    chk_reserved_low_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        strapBus.capture0[1:0] == 2'b00 && strapBus.hostClockStrap[2:0] == 3'b000)
        else $error("reserved strap bits set"); // RULE1
    chk_strap_capture_1_layout: assert property (@(posedge mclk) disable iff (sys_rst)
        strapBus.capture1[7:4] == 4'h0 && strapBus.capture1[1:0] == 2'b00)
        else $error("capture1 reserved bits set"); // RULE5
    chk_strap_capture_2_layout: assert property (@(posedge mclk) disable iff (sys_rst)
        strapBus.capture2[7:6] == 2'b00 && strapBus.capture2[4] == 1'b0)
        else $error("capture2 reserved bits set"); // RULE6
    chk_pci_divisor: assert property (@(posedge mclk) disable iff (sys_rst)
        ##1 (pci_clock_output == psc_pkg::PSC_DIV4) == !$past(strapBus.capture0[4]))
        else $error("pci divisor mismatch"); // RULE4
    chk_pll_range: assert property (@(posedge mclk) disable iff (sys_rst)
        $past(strapBus.capture0[7:6]) == 2'b01 |-> pci_clock_pll == psc_pkg::PSC_PLL_32_64)
        else $error("pll range mismatch"); // RULE2
    chk_sync_follows: assert property (@(posedge mclk) disable iff (sys_rst)
        memHostSync == $past(strapBus.capture0[5])) else $error("sync select mismatch"); // RULE3
    chk_freq_100: assert property (@(posedge mclk) disable iff (sys_rst)
        $past(strapBus.hostClockStrap[7:3]) == psc_pkg::HC_100
        |-> hostFreq == psc_pkg::PSC_HF_100)
        else $error("host freq mismatch"); // RULE8
    chk_cpu_bus_sel: assert property (@(posedge mclk) disable iff (sys_rst)
        cpuClockX2 == $past(strapBus.cpuX2) && localBusSel == $past(strapBus.localBus))
        else $error("cpu or bus select mismatch"); // RULE9
    chk_index_read: assert property (@(posedge mclk) disable iff (sys_rst)
        (ioRd && ioAddr == psc_pkg::DATA_PORT && indexReg == psc_pkg::OFS_CAPTURE0)
        |=> ioRdata == $past(strapBus.capture0)) else $error("data port read wrong"); // RULE11
    cov_release: cover property (@(posedge mclk) disable iff (sys_rst)
        $rose(system_reset_output_n));
    cov_read_hclk: cover property (@(posedge mclk) disable iff (sys_rst)
        ioRd && ioAddr == psc_pkg::DATA_PORT && indexReg == psc_pkg::OFS_HOST_CLK);
    cov_div2: cover property (@(posedge mclk) disable iff (sys_rst)
        pci_clock_output == psc_pkg::PSC_DIV2);
endmodule : psc_strap_capture

// *** hdl/psc_strap_if.sv ***
// Interface carrying the captured strap bytes between capture and decode
`timescale 1ns/10ps
interface psc_strap_if;
    logic [7:0] capture0;
    logic [7:0] capture1;
    logic [7:0] capture2;
    logic [7:0] hostClockStrap;
    logic cpuX2;
    logic localBus;
    modport src (output capture0, capture1, capture2, hostClockStrap, cpuX2, localBus);
    modport dst (input capture0, capture1, capture2, hostClockStrap, cpuX2, localBus);
endinterface : psc_strap_if

// *** hdl/psc_strap_sync.sv ***
// Three-stage synchroniser for the memory data pins
`timescale 1ns/10ps
module psc_strap_sync
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [psc_pkg::PIN_W-1:0] pinIn,
    output logic [psc_pkg::PIN_W-1:0] pinSync,
    output logic pinStable
);
    logic [psc_pkg::PIN_W-1:0] stage [psc_pkg::SYNC_DEPTH];

    genvar g;
    generate
        for (g = 0; g < psc_pkg::SYNC_DEPTH; g++)
        begin : gStage
            // Split by generate so the first stage never names a stage below zero
            if (g == 0)
            begin : gFirst
                always_ff @(posedge mclk or posedge sys_rst)
                begin
                    if (sys_rst)
                        stage[g] <= '0;
                    else
                        stage[g] <= pinIn;
                end
            end
            else
            begin : gNext
                always_ff @(posedge mclk or posedge sys_rst)
                begin
                    if (sys_rst)
                        stage[g] <= '0;
                    else
                        stage[g] <= stage[g-1];
                end
            end
        end
    endgenerate

    // Value counts only once the second and third stages agree
    assign pinSync = stage[2];
    assign pinStable = (stage[1] == stage[2]);
endmodule : psc_strap_sync

// *** test/power_on_strap_capture_bench.sv ***
// Self-checking bench for the power-on strap capture block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module power_on_strap_capture_bench;
    logic mclk = 1'h0;
    logic sysRst = 1'h1;
    logic rstInN = 1'h0;
    logic rstOutN;
    logic ioWr = 1'h0;
    logic ioRd = 1'h0;
    logic [15:0] ioAddr = 16'h0000;
    logic [7:0] ioWdata = 8'h00;
    logic [7:0] ioRdata;
    logic ioRvalid;
    psc_pkg::psc_pllrange_t pll;
    psc_pkg::psc_pcidiv_t pdiv;
    psc_pkg::psc_hfreq_t freq;
    psc_pkg::psc_hfreq_t capFreq;
    logic sync;
    logic x2;
    logic lbus;
    logic [63:0] userStraps = 64'h0000_0000_0000_0000;
    logic [63:0] pins;
    logic [63:0] capPins;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    psc_strap_board board (.userStraps(userStraps), .pins(pins));
    psc_strap_capture dut (.mclk(mclk), .sys_rst(sysRst), .memory_data_pins(pins),
        .system_reset_input_n(rstInN), .system_reset_output_n(rstOutN), .ioWr(ioWr),
        .ioRd(ioRd), .ioAddr(ioAddr), .ioWdata(ioWdata), .ioRdata(ioRdata),
        .ioRvalid(ioRvalid), .pci_clock_pll(pll), .pci_clock_output(pdiv),
        .memHostSync(sync), .hostFreq(freq), .cpuClockX2(x2), .localBusSel(lbus));
    initial
    begin
        forever #50 mclk = !mclk;
    end
    // ************************
    // Bus cycles and helpers
    // ************************
    task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic v);
        ioWr = w;
        ioRd = !w;
        ioAddr = a;
        ioWdata = d;
        @(posedge mclk);
        #1;
        v = ioRvalid;
        q = ioRdata;
        #4;
        ioWr = 1'h0;
        ioRd = 1'h0;
        @(posedge mclk);
        #5;
    endtask : io
    task automatic rd_reg(input logic [7:0] ofs, output logic [7:0] q);
        logic v;
        io(1'h1, psc_pkg::IDX_PORT, ofs, q, v);
        io(1'h0, psc_pkg::DATA_PORT, 8'h00, q, v);
        `CHK("ioRvalid", 1'h1, v)
    endtask : rd_reg
    function automatic logic [7:0] exp_reg(int k, logic [63:0] p);
        case (k)
            0: return {p[7:2], 2'h0};
            1: return {4'h0, p[11:10], 2'h0};
            2: return {2'h0, p[23], 1'h0, p[19:16]};
            default: return {p[3], p[2], p[26:24], 3'h0};
        endcase
    endfunction : exp_reg
    task automatic check_all();
        logic [7:0] ofs [4] = '{8'h4A, 8'h4B, 8'h4C, 8'h5F};
        logic [7:0] q;
        psc_pkg::psc_pcidiv_t expDiv;
        for (int k = 0; k < 4; k++)
        begin
            rd_reg(ofs[k], q);
            `CHK("strap reg", exp_reg(k, capPins), q)
        end
        `CHK("pll", capPins[6] ? psc_pkg::PSC_PLL_32_64 : psc_pkg::PSC_PLL_16_32, pll)
        `CHK("sync", capPins[5], sync)
        if (!capPins[4])
            expDiv = psc_pkg::PSC_DIV4;
        else
            expDiv = capPins[17] ? psc_pkg::PSC_DIV2 : psc_pkg::PSC_DIV3;
        `CHK("div", expDiv, pdiv)
        `CHK("freq", capFreq, freq)
        `CHK("x2", capPins[40], x2)
        `CHK("lbus", capPins[44], lbus)
    endtask : check_all
    // Straps change before reset input drops, with the capture frozen except on the first call, then a warm reset samples them
    task automatic warm_reset(input logic [63:0] s);
        int n;
        userStraps = s;
        rstInN = 1'h0;
        repeat (4) @(posedge mclk);
        #5;
        `CHK("rstOutN low", 1'h0, rstOutN)
        rstInN = 1'h1;
        capPins = pins;
        for (n = 0; n < 10 && rstOutN !== 1'h1; n++)
        begin
            @(posedge mclk);
            #5;
        end
        `CHK("rstOut delay", 1'h1, n >= 3 && n <= 6)
        repeat (2) @(posedge mclk);
        #5;
    endtask : warm_reset
    // ************************
    // Scenarios
    // ************************
    task automatic test_decode();
        logic [4:0] code [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h09, 5'h0E, 5'h13, 5'h19, 5'h1F};
        logic [63:0] s;
        for (int i = 0; i < 9; i++)
        begin
            s = {64{i[0]}} ^ 64'h0000_0000_0000_0040;
            {s[3], s[2], s[26:24]} = code[i];
            {s[4], s[17], s[5], s[40], s[44]} = {i[0], i[1], i[2], i[1], i[2]};
            {s[11], s[10], s[6]} = {i[0], i[1], i[0] ^ i[1]};
            capFreq = (i < 8) ? psc_pkg::psc_hfreq_t'(i) : psc_pkg::PSC_HF_RSV;
            warm_reset(s);
            check_all();
        end
        $display("test decode done");
    endtask : test_decode
    task automatic test_freeze();
        userStraps = ~userStraps;
        repeat (5) @(posedge mclk);
        #5;
        check_all();
        $display("test freeze done");
    endtask : test_freeze
    task automatic test_port();
        logic [7:0] q;
        logic v;
        rd_reg(8'h4A, q);
        io(1'h1, psc_pkg::DATA_PORT, ~q, q, v);
        io(1'h0, psc_pkg::IDX_PORT, 8'h00, q, v);
        `CHK("index readback", 8'h4A, q)
        io(1'h0, psc_pkg::DATA_PORT, 8'h00, q, v);
        `CHK("read only", exp_reg(0, capPins), q)
        io(1'h1, 16'h0080, 8'h4B, q, v);
        io(1'h0, 16'h0080, 8'h00, q, v);
        `CHK("other address", 1'h0, v)
        io(1'h0, psc_pkg::IDX_PORT, 8'h00, q, v);
        `CHK("index kept", 8'h4A, q)
        rd_reg(8'h50, q);
        `CHK("unmapped", 8'hFF, q)
        $display("test port done");
    endtask : test_port
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (2) @(posedge mclk);
        #5;
        sysRst = 1'h0;
        @(posedge mclk);
        #5;
        test_decode();
        test_freeze();
        test_port();
        end_of_test();
    end
endmodule : power_on_strap_capture_bench

// *** test/psc_strap_board.sv ***
// Board strap resistor model driving the memory data pins
`timescale 1ns/10ps
module psc_strap_board
(
    input wire logic [63:0] userStraps,
    output logic [63:0] pins
);
    // Reserved straps are held by fixed pulls whatever the user setting says
    localparam logic [63:0] FIXED = 64'h0001_EE00_78FD_0C80;
    localparam logic [63:0] PULL_UP = 64'h0001_4400_00FD_0000;
    always_comb
    begin
        pins = (userStraps & ~FIXED) | PULL_UP;
    end
endmodule : psc_strap_board
